// File: logic/ssf_pkg.sv
/*
 * Constants for the sample sequencer result FIFO block: register offsets,
 * field positions, reset values and event bit layout.
 * Assumes a 12-bit APB byte address and 32-bit data.
 */
package ssf_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 10;
	localparam int IDX_W = 3;
	// register byte offsets
	localparam logic [11:0] OFS_IRQ_MASK = 12'h008;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h00c;
	localparam logic [11:0] OFS_OVF_STAT = 12'h010;
	localparam logic [11:0] OFS_UNF_STAT = 12'h018;
	localparam logic [11:0] OFS_FIFO0 = 12'h048;
	localparam logic [11:0] OFS_STAT0 = 12'h04c;
	localparam logic [11:0] OFS_MUX1 = 12'h060;
	localparam logic [11:0] OFS_CTL1 = 12'h064;
	localparam logic [11:0] OFS_FIFO1 = 12'h068;
	localparam logic [11:0] OFS_STAT1 = 12'h06c;
	localparam logic [11:0] OFS_MUX2 = 12'h080;
	localparam logic [11:0] OFS_CTL2 = 12'h084;
	localparam logic [11:0] OFS_FIFO2 = 12'h088;
	localparam logic [11:0] OFS_STAT2 = 12'h08c;
	localparam logic [11:0] OFS_MUX3 = 12'h0a0;
	localparam logic [11:0] OFS_CTL3 = 12'h0a4;
	localparam logic [11:0] OFS_FIFO3 = 12'h0a8;
	localparam logic [11:0] OFS_STAT3 = 12'h0ac;
	// fifo status fields
	localparam int STAT_FULL_BIT = 12;
	localparam int STAT_EMPTY_BIT = 8;
	localparam int STAT_WR_LSB = 4;
	localparam int STAT_RD_LSB = 0;
	localparam logic [31:0] STAT_RESET = 32'h00000100;
	// sample control nibble fields
	localparam int CTL_DIFF_BIT = 0;
	localparam int CTL_LAST_BIT = 1;
	localparam int CTL_IE_BIT = 2;
	localparam int CTL_TS_BIT = 3;
	localparam logic [15:0] MUX_RESET = 16'h0000;
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [3:0] CTL3_RESET = 4'h2;
	localparam logic [3:0] CTL3_FIXED = 4'h2;
	// interrupt status layout
	localparam int IRQ_SAMPLE_LSB = 0;
	localparam int IRQ_OVF_LSB = 4;
	localparam int IRQ_UNF_LSB = 8;
	localparam int IRQ_W = 12;
endpackage : ssf_pkg

// File: logic/ssf_top.sv
/*
 * Result FIFOs and FIFO status views of four sample sequencers, input-select
 * and sample-control registers of sequencers 1 to 3, with APB slave and interrupt.
 * Assumes the conversion engine sits on CLK_I and presents a finished
 * result as a one-cycle CONV_DONE_I pulse; it looks up sample settings
 * through the CFG_* ports.
 */
`timescale 1ns/10ps
module ssf_top #(
	parameter int DEPTH0 = 8,
	parameter int DEPTH1 = 4,
	parameter int DEPTH2 = 4,
	parameter int DEPTH3 = 1
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic CONV_DONE_I,
	input wire logic [1:0] CONV_SEQ_I,
	input wire logic [2:0] CONV_STEP_I,
	input wire logic [9:0] CONV_DATA_I,
	input wire logic [1:0] CFG_SEQ_I,
	input wire logic [2:0] CFG_STEP_I,
	output logic [3:0] CFG_INPUT_O,
	output logic [3:0] CFG_CTRL_O,
	output logic CFG_ACTIVE_O,
	output logic IRQ_O
);
	logic [15:0] input_select_seq1;
	logic [15:0] sample_control_seq1;
	logic [15:0] input_select_seq2;
	logic [15:0] sample_control_seq2;
	logic [3:0] input_select_seq3;
	logic [3:0] sample_control_seq3;
	logic [3:0] overflow_status_reg;
	logic [3:0] underflow_status_reg;
	logic [11:0] irq_stat;
	logic [11:0] irq_mask;
	logic [3:0] full_v;
	logic [3:0] empty_v;
	logic [3:0] push_v;
	logic [3:0] pop_v;
	logic [3:0] smp_ev;
	logic [2:0] wr_v [4];
	logic [2:0] rd_v [4];
	logic [9:0] head_v [4];
	logic [31:0] rd_val;
	logic hit;
	logic rd_fire;
	logic wr_fire;
	logic conv_on;
	logic [3:0] conv_ctl;

	// depth of each fifo; indexes are 3 bits so depth may not pass 8
	function automatic int fifo_depth(input int s);
		case (s)
			0: return DEPTH0;
			1: return DEPTH1;
			2: return DEPTH2;
			default: return DEPTH3;
		endcase
	endfunction : fifo_depth

	function automatic logic [11:0] fifo_ofs(input int s);
		case (s)
			0: return ssf_pkg::OFS_FIFO0;
			1: return ssf_pkg::OFS_FIFO1;
			2: return ssf_pkg::OFS_FIFO2;
			default: return ssf_pkg::OFS_FIFO3;
		endcase
	endfunction : fifo_ofs

	// control nibble of one sample position
	function automatic logic [3:0] ctl_nib(input logic [1:0] s, input logic [2:0] st);
		case (s)
			2'h1: return sample_control_seq1[{st[1:0], 2'b00} +: 4];
			2'h2: return sample_control_seq2[{st[1:0], 2'b00} +: 4];
			2'h3: return sample_control_seq3 | ssf_pkg::CTL3_FIXED;
			default: return 4'h0;
		endcase
	endfunction : ctl_nib

	function automatic logic [3:0] mux_nib(input logic [1:0] s, input logic [2:0] st);
		case (s)
			2'h1: return input_select_seq1[{st[1:0], 2'b00} +: 4];
			2'h2: return input_select_seq2[{st[1:0], 2'b00} +: 4];
			2'h3: return input_select_seq3;
			default: return 4'h0;
		endcase
	endfunction : mux_nib

	// a position runs only if no earlier position carries the last flag
	function automatic logic step_on(input logic [1:0] s, input logic [2:0] st);
		logic on;
		logic [3:0] nib;
		on = 1'b1;
		nib = 4'h0;
		if ((s == 2'h1 || s == 2'h2) && st > 3'h3)
			on = 1'b0;
		if (s == 2'h3 && st != 3'h0)
			on = 1'b0;
		for (int k = 0; k < 4; k++) begin
			nib = ctl_nib(s, 3'(k));
			if (s != 2'h0 && 3'(k) < st && nib[ssf_pkg::CTL_LAST_BIT])
				on = 1'b0;
		end
		return on;
	endfunction : step_on

	function automatic logic [31:0] stat_word(input int s);
		logic [31:0] w;
		w = 32'h0;
		w[ssf_pkg::STAT_FULL_BIT] = full_v[s];
		w[ssf_pkg::STAT_EMPTY_BIT] = empty_v[s];
		w[ssf_pkg::STAT_WR_LSB +: 4] = {1'b0, wr_v[s]};
		w[ssf_pkg::STAT_RD_LSB +: 4] = {1'b0, rd_v[s]};
		return w;
	endfunction : stat_word

	// data pops in the first access cycle, the answer stands in the second
	assign rd_fire = PSEL_I && PENABLE_I && !PWRITE_I && !PREADY_O;
	assign wr_fire = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;

	// engine position decode kept in a process: a plain assign wakes only on
	// its arguments and would miss a config write seen inside the functions
	always_comb begin
		conv_on = step_on(CONV_SEQ_I, CONV_STEP_I);
		conv_ctl = ctl_nib(CONV_SEQ_I, CONV_STEP_I);
	end

	// one fifo per sequencer, storage in flops indexed by slot
	for (genvar g = 0; g < 4; g++) begin : g_fifo
		localparam int D = fifo_depth(g);
		logic [9:0] slot [8];
		logic [2:0] wr;
		logic [2:0] rd;
		logic last_push;
		logic push_ok;
		logic pop_ok;
		logic [31:0] stat_w;
		assign push_v[g] = CONV_DONE_I && CONV_SEQ_I == 2'(g) && conv_on;
		assign pop_v[g] = rd_fire && PADDR_I == fifo_ofs(g);
		assign full_v[g] = (wr == rd) && last_push;
		assign empty_v[g] = (wr == rd) && !last_push;
		assign push_ok = push_v[g] && !full_v[g];
		assign pop_ok = pop_v[g] && !empty_v[g];
		assign wr_v[g] = wr;
		assign rd_v[g] = rd;
		assign head_v[g] = slot[rd];
		assign smp_ev[g] = CONV_DONE_I && CONV_SEQ_I == 2'(g) && conv_on
			&& conv_ctl[ssf_pkg::CTL_IE_BIT];

		// status word as software sees it, watched by the checks below
		always_comb begin
			stat_w = stat_word(g);
		end

		always_ff @(posedge CLK_I) begin
			if (push_ok)
				slot[wr] <= CONV_DATA_I;
		end

		// indexes reset to zero with last op a pop, so status is 0x100
		always_ff @(posedge CLK_I or posedge RST_I) begin
			if (RST_I) begin
				wr <= 3'h0;
				rd <= 3'h0;
				last_push <= 1'b0;
			end else begin
				if (push_ok)
					wr <= (wr == 3'(D - 1)) ? 3'h0 : wr + 3'h1;
				if (pop_ok)
					rd <= (rd == 3'(D - 1)) ? 3'h0 : rd + 3'h1;
				if (push_ok && !pop_ok)
					last_push <= 1'b1;
				else if (pop_ok && !push_ok)
					last_push <= 1'b0;
			end
		end
	end

	// read decode; reserved upper bits of a result read as zero
	always_comb begin
		rd_val = 32'h0;
		hit = 1'b1;
		case (PADDR_I)
			ssf_pkg::OFS_IRQ_MASK: rd_val = {20'h0, irq_mask};
			ssf_pkg::OFS_IRQ_STAT: rd_val = {20'h0, irq_stat};
			ssf_pkg::OFS_OVF_STAT: rd_val = {28'h0, overflow_status_reg};
			ssf_pkg::OFS_UNF_STAT: rd_val = {28'h0, underflow_status_reg};
			ssf_pkg::OFS_FIFO0: rd_val = {22'h0, head_v[0]};
			ssf_pkg::OFS_FIFO1: rd_val = {22'h0, head_v[1]};
			ssf_pkg::OFS_FIFO2: rd_val = {22'h0, head_v[2]};
			ssf_pkg::OFS_FIFO3: rd_val = {22'h0, head_v[3]};
			ssf_pkg::OFS_STAT0: rd_val = stat_word(0);
			ssf_pkg::OFS_STAT1: rd_val = stat_word(1);
			ssf_pkg::OFS_STAT2: rd_val = stat_word(2);
			ssf_pkg::OFS_STAT3: rd_val = stat_word(3);
			ssf_pkg::OFS_MUX1: rd_val = {16'h0, input_select_seq1};
			ssf_pkg::OFS_CTL1: rd_val = {16'h0, sample_control_seq1};
			ssf_pkg::OFS_MUX2: rd_val = {16'h0, input_select_seq2};
			ssf_pkg::OFS_CTL2: rd_val = {16'h0, sample_control_seq2};
			ssf_pkg::OFS_MUX3: rd_val = {28'h0, input_select_seq3};
			ssf_pkg::OFS_CTL3: rd_val = {28'h0, sample_control_seq3};
			default: hit = 1'b0;
		endcase
	end

	// apb answer: one wait state so read data comes from a flop
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O <= 32'h0;
		end else if (PSEL_I && PENABLE_I && !PREADY_O) begin
			PREADY_O <= 1'b1;
			PSLVERR_O <= !hit;
			PRDATA_O <= PWRITE_I ? 32'h0 : rd_val;
		end else begin
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
		end
	end

	// sequencer configuration registers
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			input_select_seq1 <= ssf_pkg::MUX_RESET;
			sample_control_seq1 <= ssf_pkg::CTL_RESET;
			input_select_seq2 <= ssf_pkg::MUX_RESET;
			sample_control_seq2 <= ssf_pkg::CTL_RESET;
			input_select_seq3 <= 4'h0;
			sample_control_seq3 <= ssf_pkg::CTL3_RESET;
		end else if (wr_fire) begin
			case (PADDR_I)
				ssf_pkg::OFS_MUX1: input_select_seq1 <= PWDATA_I[15:0];
				ssf_pkg::OFS_CTL1: sample_control_seq1 <= PWDATA_I[15:0];
				ssf_pkg::OFS_MUX2: input_select_seq2 <= PWDATA_I[15:0];
				ssf_pkg::OFS_CTL2: sample_control_seq2 <= PWDATA_I[15:0];
				ssf_pkg::OFS_MUX3: input_select_seq3 <= PWDATA_I[3:0];
				ssf_pkg::OFS_CTL3: sample_control_seq3 <= PWDATA_I[3:0] | ssf_pkg::CTL3_FIXED;
				ssf_pkg::OFS_IRQ_MASK: ;
				default: ;
			endcase
		end
	end

	// sticky event flags, write one to clear; a new event beats the clear
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			overflow_status_reg <= 4'h0;
			underflow_status_reg <= 4'h0;
			irq_stat <= 12'h0;
			irq_mask <= 12'h0;
		end else begin
			overflow_status_reg <= (overflow_status_reg
				& ~((wr_fire && PADDR_I == ssf_pkg::OFS_OVF_STAT) ? PWDATA_I[3:0] : 4'h0))
				| (push_v & full_v);
			underflow_status_reg <= (underflow_status_reg
				& ~((wr_fire && PADDR_I == ssf_pkg::OFS_UNF_STAT) ? PWDATA_I[3:0] : 4'h0))
				| (pop_v & empty_v);
			irq_stat <= (irq_stat
				& ~((wr_fire && PADDR_I == ssf_pkg::OFS_IRQ_STAT) ? PWDATA_I[11:0] : 12'h0))
				| {pop_v & empty_v, push_v & full_v, smp_ev};
			if (wr_fire && PADDR_I == ssf_pkg::OFS_IRQ_MASK)
				irq_mask <= PWDATA_I[11:0];
		end
	end

	// level interrupt, one cycle behind the status bits
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= |(irq_stat & irq_mask);
	end

	// registered lookup of a sample position's settings for the engine
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			CFG_INPUT_O <= 4'h0;
			CFG_CTRL_O <= 4'h0;
			CFG_ACTIVE_O <= 1'b0;
		end else begin
			CFG_INPUT_O <= mux_nib(CFG_SEQ_I, CFG_STEP_I);
			CFG_CTRL_O <= ctl_nib(CFG_SEQ_I, CFG_STEP_I);
			CFG_ACTIVE_O <= step_on(CFG_SEQ_I, CFG_STEP_I);
		end
	end

	chk_pop_advance: assert property (@(posedge CLK_I) disable iff (RST_I)
		pop_v[1] && !empty_v[1] |=> rd_v[1] == (($past(rd_v[1]) == 3'(DEPTH1 - 1)) ? 3'h0
			: $past(rd_v[1]) + 3'h1)) else $error("read index did not advance on pop");
	chk_overflow_set: assert property (@(posedge CLK_I) disable iff (RST_I)
		push_v[2] && full_v[2] |=> overflow_status_reg[2] && irq_stat[ssf_pkg::IRQ_OVF_LSB + 2])
		else $error("overflow not recorded");
	chk_underflow_set: assert property (@(posedge CLK_I) disable iff (RST_I)
		pop_v[2] && empty_v[2] |=> underflow_status_reg[2] ##1 PREADY_O == 1'b0)
		else $error("underflow not recorded");
	chk_result_upper: assert property (@(posedge CLK_I) disable iff (RST_I)
		rd_fire && PADDR_I == ssf_pkg::OFS_FIFO0 |=> PREADY_O && PRDATA_O[31:10] == 22'h0)
		else $error("result upper bits not zero");
	chk_full_cause: assert property (@(posedge CLK_I) disable iff (RST_I)
		$rose(full_v[2]) |-> $past(push_v[2]) && g_fifo[2].stat_w[ssf_pkg::STAT_FULL_BIT]
			&& $past(wr_v[2]) != wr_v[2]) else $error("full without a push");
	chk_empty_cause: assert property (@(posedge CLK_I) disable iff (RST_I)
		$rose(empty_v[0]) |-> $past(pop_v[0]) && g_fifo[0].stat_w[ssf_pkg::STAT_EMPTY_BIT])
		else $error("empty without a pop");
	chk_push_discard: assert property (@(posedge CLK_I) disable iff (RST_I)
		push_v[2] && full_v[2] && !pop_v[2] |=> $stable(wr_v[2]) && full_v[2])
		else $error("push into full fifo changed it");
	chk_past_last: assert property (@(posedge CLK_I) disable iff (RST_I)
		CONV_DONE_I && CONV_SEQ_I == 2'h1 && !conv_on |=> $stable(wr_v[1]) && $stable(full_v[1]))
		else $error("sample after last was stored");
	chk_sample_irq: assert property (@(posedge CLK_I) disable iff (RST_I)
		smp_ev[1] |=> irq_stat[ssf_pkg::IRQ_SAMPLE_LSB + 1])
		else $error("sample interrupt missing");
	chk_last_fixed: assert property (@(posedge CLK_I) disable iff (RST_I)
		sample_control_seq3[ssf_pkg::CTL_LAST_BIT] && step_on(2'h3, 3'h0)
			&& !step_on(2'h3, 3'h1)) else $error("sequencer 3 last flag clear");

	// further guards on bus timing, flags, indexes and the lookup
	chk_ready_pulse: assert property (@(posedge CLK_I) disable iff (RST_I)
		rd_fire |=> PREADY_O ##1 !PREADY_O)
		else $error("read answer not a single ready pulse");
	chk_pop_data: assert property (@(posedge CLK_I) disable iff (RST_I)
		rd_fire && PADDR_I == ssf_pkg::OFS_FIFO1 && !empty_v[1]
			|=> PRDATA_O[9:0] == $past(head_v[1]))
		else $error("popped data is not the oldest entry");
	chk_push_advance: assert property (@(posedge CLK_I) disable iff (RST_I)
		push_v[2] && !full_v[2] |=> wr_v[2] == (($past(wr_v[2]) == 3'(DEPTH2 - 1)) ? 3'h0
			: $past(wr_v[2]) + 3'h1)) else $error("write index did not advance on push");
	chk_empty_read: assert property (@(posedge CLK_I) disable iff (RST_I)
		pop_v[0] && empty_v[0] |=> $stable(rd_v[0]))
		else $error("read of empty fifo moved the read index");
	chk_write_lands: assert property (@(posedge CLK_I) disable iff (RST_I)
		wr_fire && PADDR_I == ssf_pkg::OFS_CTL1
			|=> sample_control_seq1 == $past(PWDATA_I[15:0]))
		else $error("control write did not land");
	chk_sticky_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
		overflow_status_reg[2] && !(wr_fire && PADDR_I == ssf_pkg::OFS_OVF_STAT)
			|=> overflow_status_reg[2]) else $error("overflow flag lost without a clear");
	chk_underflow_irq: assert property (@(posedge CLK_I) disable iff (RST_I)
		pop_v[1] && empty_v[1] |=> irq_stat[ssf_pkg::IRQ_UNF_LSB + 1])
		else $error("underflow event missing");
	chk_single_step: assert property (@(posedge CLK_I) disable iff (RST_I)
		CFG_SEQ_I == 2'h3 && CFG_STEP_I != 3'h0 |=> !CFG_ACTIVE_O)
		else $error("sequencer 3 reported a second position");
	chk_irq_level: assert property (@(posedge CLK_I) disable iff (RST_I)
		|(irq_stat & irq_mask) |=> IRQ_O)
		else $error("unmasked flag did not raise interrupt");
	chk_irq_quiet: assert property (@(posedge CLK_I) disable iff (RST_I)
		!(|(irq_stat & irq_mask)) |=> !IRQ_O)
		else $error("interrupt high with no unmasked flag");
endmodule : ssf_top

// File: tb/ssf_bench.sv
/*
 * Self-checking bench for ssf_top: a queue model of the four result fifos,
 * their status views, the config registers and the event flags.
 * Assumes ssf_pkg is compiled first and the design answers apb with one wait state.
 */
`timescale 1ns/10ps
module sample_sequence_result_fifos_test;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, done = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rdat, d;
	logic pready, pslverr, irq, cfg_act, err;
	logic [1:0] cseq = 2'h0, qseq = 2'h0;
	logic [2:0] cstep = 3'h0, qstep = 3'h0;
	logic [9:0] cdata = 10'h000;
	logic [3:0] cfg_in, cfg_ctl;
	int n_mismatch = 0, checks_done = 0;
	int dep[4] = '{8, 4, 4, 1};
	int wr[4] = '{0, 0, 0, 0};
	int rd[4] = '{0, 0, 0, 0};
	logic [9:0] q[4][$];
	logic [15:0] mux[4], ctl[4];
	logic [31:0] ovf = 32'h0, unf = 32'h0, irqs = 32'h0;
	logic [11:0] fa[4] = '{ssf_pkg::OFS_FIFO0, ssf_pkg::OFS_FIFO1, ssf_pkg::OFS_FIFO2,
		ssf_pkg::OFS_FIFO3};
	logic [11:0] sa[4] = '{ssf_pkg::OFS_STAT0, ssf_pkg::OFS_STAT1, ssf_pkg::OFS_STAT2,
		ssf_pkg::OFS_STAT3};

	// free-running system clock, 100 mhz
	always #5 clk = ~clk;

	ssf_top ssf_top_inst (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .CONV_DONE_I(done), .CONV_SEQ_I(cseq),
		.CONV_STEP_I(cstep), .CONV_DATA_I(cdata), .CFG_SEQ_I(qseq), .CFG_STEP_I(qstep),
		.CFG_INPUT_O(cfg_in), .CFG_CTRL_O(cfg_ctl), .CFG_ACTIVE_O(cfg_act), .IRQ_O(irq));

	task conclude;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask : chk

	// one apb transfer; held until pready is seen high at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
		int k;
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			conclude();
		end
		rdat = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb

	task rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		chk($sformatf("reg %h", a), e, rdat);
	endtask : rdchk

	function logic [31:0] stat(input int s);
		return {19'h0, q[s].size() == dep[s], 3'h0, q[s].size() == 0, wr[s][3:0], rd[s][3:0]};
	endfunction : stat

	// positions after the flagged last one are never converted
	function bit act(input int s, input int st);
		if (s == 0) return 1;
		if (s == 3) return st == 0;
		if (st > 3) return 0;
		for (int j = 0; j < st; j++) if (ctl[s][4*j+1]) return 0;
		return 1;
	endfunction : act

	task push(input int s, input int st);
		logic [9:0] v;
		bit a;
		v = 10'($urandom);
		a = act(s, st);
		@(posedge clk);
		done <= 1;
		cseq <= s[1:0];
		cstep <= st[2:0];
		cdata <= v;
		qseq <= s[1:0];
		qstep <= st[2:0];
		@(posedge clk);
		done <= 0;
		@(posedge clk);
		chk("cfg active", a, cfg_act);
		if (s > 0 && a) begin
			chk("cfg input", mux[s][4*st+:4], cfg_in);
			chk("cfg ctrl", ctl[s][4*st+:4], cfg_ctl);
		end
		if (a && q[s].size() < dep[s]) begin
			q[s].push_back(v);
			wr[s] = (wr[s] + 1) % dep[s];
			if (s > 0 && ctl[s][4*st+2]) irqs[s] = 1;
		end else if (a) begin
			ovf[s] = 1;
			irqs[4+s] = 1;
		end
		rdchk(sa[s], stat(s));
	endtask : push

	task pop(input int s);
		apb(0, fa[s], 32'h0);
		if (q[s].size() > 0) begin
			chk("fifo data", {22'h0, q[s].pop_front()}, rdat);
			rd[s] = (rd[s] + 1) % dep[s];
		end else begin
			unf[s] = 1;
			irqs[8+s] = 1;
		end
		rdchk(sa[s], stat(s));
	endtask : pop

	// a hang anywhere ends the run as a mismatch
	initial begin
		repeat (50000) @(posedge clk);
		n_mismatch++;
		conclude();
	end

	initial begin
		d = $urandom(51426);
		repeat (4) @(posedge clk);
		rst <= 0;
		for (int s = 0; s < 4; s++) rdchk(sa[s], ssf_pkg::STAT_RESET);
		rdchk(ssf_pkg::OFS_CTL3, 32'h2);
		d = $urandom;
		apb(1, ssf_pkg::OFS_MUX1, d);
		rdchk(ssf_pkg::OFS_MUX1, d & 32'hffff);
		apb(1, ssf_pkg::OFS_CTL2, d | 32'h2);
		rdchk(ssf_pkg::OFS_CTL2, (d | 32'h2) & 32'hffff);
		apb(1, ssf_pkg::OFS_MUX3, d);
		rdchk(ssf_pkg::OFS_MUX3, d & 32'hf);
		apb(1, ssf_pkg::OFS_CTL3, d & 32'h9);
		rdchk(ssf_pkg::OFS_CTL3, (d & 32'h9) | 32'h2);
		// last flag at step 1 of seq1 with irq on step 0; seq2 ends at step 3
		mux[0] = 16'h0;
		ctl[0] = 16'h0;
		mux[1] = 16'h3210;
		ctl[1] = 16'h0024;
		mux[2] = 16'($urandom);
		ctl[2] = 16'h2000;
		mux[3] = d[15:0] & 16'hf;
		ctl[3] = (d[15:0] & 16'h9) | 16'h2;
		apb(1, ssf_pkg::OFS_MUX1, {16'h0, mux[1]});
		apb(1, ssf_pkg::OFS_CTL1, {16'h0, ctl[1]});
		apb(1, ssf_pkg::OFS_MUX2, {16'h0, mux[2]});
		apb(1, ssf_pkg::OFS_CTL2, {16'h0, ctl[2]});
		for (int st = 0; st < 4; st++) push(1, st);
		for (int i = 0; i < 5; i++) push(2, 0);
		for (int i = 0; i < 3; i++) push(0, $urandom_range(7));
		push(3, 0);
		push(3, 0);
		push(3, 1);
		rdchk(ssf_pkg::OFS_OVF_STAT, ovf);
		for (int s = 0; s < 4; s++) repeat (q[s].size() + 1) pop(s);
		rdchk(ssf_pkg::OFS_UNF_STAT, unf);
		// flags set but masked: line stays low until the mask opens
		chk("irq masked", 32'h0, irq);
		rdchk(ssf_pkg::OFS_IRQ_STAT, irqs);
		apb(1, ssf_pkg::OFS_IRQ_MASK, 32'h00000fff);
		repeat (2) @(posedge clk);
		chk("irq open", 32'h1, irq);
		apb(1, ssf_pkg::OFS_IRQ_STAT, irqs);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, irq);
		rdchk(ssf_pkg::OFS_IRQ_STAT, 32'h0);
		rdchk(ssf_pkg::OFS_IRQ_MASK, 32'hfff);
		apb(1, ssf_pkg::OFS_OVF_STAT, ovf);
		rdchk(ssf_pkg::OFS_OVF_STAT, 32'h0);
		apb(1, ssf_pkg::OFS_UNF_STAT, unf);
		rdchk(ssf_pkg::OFS_UNF_STAT, 32'h0);
		apb(1, sa[1], 32'hffffffff);
		rdchk(sa[1], stat(1));
		apb(0, 12'hffc, 32'h0);
		chk("unmapped error", 32'h1, err);
		chk("unmapped data", 32'h0, rdat);
		conclude();
	end
endmodule : sample_sequence_result_fifos_test
